// ### verilog/frame_align_err_pkg.sv
package frame_align_err_pkg;

    // Printed offsets are not multiples of four, so they are indices.
    localparam logic [15:0] FRAME_ALIGN_ERR_COUNT_HIGH_IDX = 16'h0902;
    localparam logic [15:0] FRAME_ALIGN_ERR_COUNT_LOW_IDX = 16'h0903;
    localparam logic [17:0] FRAME_ALIGN_ERR_COUNT_HIGH_ADDR =
        {FRAME_ALIGN_ERR_COUNT_HIGH_IDX, 2'b00};
    localparam logic [17:0] FRAME_ALIGN_ERR_COUNT_LOW_ADDR =
        {FRAME_ALIGN_ERR_COUNT_LOW_IDX, 2'b00};

    // Field layout of the count and the byte registers.
    localparam int COUNT_WIDTH = 16;
    localparam int BYTE_WIDTH = 8;
    localparam int HIGH_BYTE_LSB = 8;
    localparam int LOW_BYTE_LSB = 0;

    // Reset values.
    localparam logic [15:0] COUNT_RESET = 16'h0000;
    localparam logic [7:0] BYTE_RESET = 8'h00;

    // AHB-Lite encodings used by the slave.
    localparam logic [1:0] HTRANS_NONSEQ = 2'b10;
    localparam logic [1:0] HTRANS_SEQ = 2'b11;
    localparam logic [2:0] HSIZE_WORD = 3'b010;

endpackage

// ### verilog/err_event_sync.sv
module err_event_sync
    import frame_align_err_pkg::*;
(
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic async_in,
    output logic rise_pulse
);

    logic meta_reg;
    logic sync_reg;
    logic last_reg;

    // Two flops before any logic looks at the pin; the edge detect uses
    // only the second and third stages so metastability cannot leak into the count.
    always_ff @(posedge clk)
    begin
        if (sys_rst)
        begin
            meta_reg <= 1'b0;
            sync_reg <= 1'b0;
            last_reg <= 1'b0;
            rise_pulse <= 1'b0;
        end
        else
        begin
            meta_reg <= async_in;
            sync_reg <= meta_reg;
            last_reg <= sync_reg;
            rise_pulse <= sync_reg & ~last_reg;
        end
    end

endmodule

// ### verilog/sat_event_counter.sv
module sat_event_counter
    import frame_align_err_pkg::*;
(
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic event_pulse,
    input wire logic clear,
    output logic [COUNT_WIDTH-1:0] count
);

    logic [COUNT_WIDTH-1:0] count_next;
    wire logic at_max = &count;

    // An event in the clear cycle starts the new period at one, so it is
    // never lost. The count sticks at full scale rather than wrapping.
    assign count_next = clear ? {{(COUNT_WIDTH-1){1'b0}}, event_pulse} :
        (event_pulse && !at_max) ? count + 16'h0001 : count;

    always_ff @(posedge clk)
    begin
        if (sys_rst)
            count <= COUNT_RESET;
        else
            count <= count_next;
    end

endmodule

// ### verilog/framing_align_error_counter.sv
// Notes on behaviour
// - Count is 16 bits, upper byte at index 0x0902, lower at 0x0903.
// - Each framing alignment error event adds one to the count, up to 0xFFFF, where the count sticks.
// - Reading clears counter bits; after reset both bytes read zero.
// - Upper register returns bits 15..8, lower register bits 7..0.
// - Upper then lower read pair clears the full count at the upper read; events between the two reads stay counted.
module framing_align_error_counter
    import frame_align_err_pkg::*;
(
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic frame_align_err,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic hreadyout,
    output logic hresp,
    output logic [31:0] hrdata
);

    logic err_pulse;
    logic [COUNT_WIDTH-1:0] count;
    logic [BYTE_WIDTH-1:0] low_hold_reg;
    logic low_hold_valid_reg;
    logic [31:0] hrdata_next;

    // The error strobe comes from the framer's own timing, so resync it.
    err_event_sync u_sync
    (
        .clk(clk),
        .sys_rst(sys_rst),
        .async_in(frame_align_err),
        .rise_pulse(err_pulse)
    );

    // Address phase decode; only word reads at the two indices act.
    wire logic xfer_valid = hsel && hready && htrans[1];
    wire logic word_ok = (hsize == HSIZE_WORD) && (haddr[1:0] == 2'b00);
    wire logic addr_high = (haddr[17:0] == FRAME_ALIGN_ERR_COUNT_HIGH_ADDR)
        && (haddr[31:18] == 14'h0000);
    wire logic addr_low = (haddr[17:0] == FRAME_ALIGN_ERR_COUNT_LOW_ADDR)
        && (haddr[31:18] == 14'h0000);
    wire logic rd_high = xfer_valid && !hwrite && word_ok && addr_high;
    wire logic rd_low = xfer_valid && !hwrite && word_ok && addr_low;

    // Clear the live count on the upper read, in the same cycle the low byte is
    // parked in the holding register, so nothing between the two reads is
    // lost; a lone lower read clears the live count as well.
    wire logic clear_count = rd_high || (rd_low && !low_hold_valid_reg);

    sat_event_counter u_count
    (
        .clk(clk),
        .sys_rst(sys_rst),
        .event_pulse(err_pulse),
        .clear(clear_count),
        .count(count)
    );

    // Read data is formed in the address phase and registered, so it
    // stands on hrdata through the whole data phase.
    always_comb
    begin
        hrdata_next = 32'h0000_0000;
        if (rd_high)
            hrdata_next[7:0] = count[HIGH_BYTE_LSB +: BYTE_WIDTH];
        else if (rd_low && low_hold_valid_reg)
            hrdata_next[7:0] = low_hold_reg;
        else if (rd_low)
            hrdata_next[7:0] = count[LOW_BYTE_LSB +: BYTE_WIDTH];
    end

    // Holding register for the lower byte of an ordered read pair.
    always_ff @(posedge clk)
    begin
        if (sys_rst)
        begin
            low_hold_reg <= BYTE_RESET;
            low_hold_valid_reg <= 1'b0;
        end
        else if (rd_high)
        begin
            low_hold_reg <= count[LOW_BYTE_LSB +: BYTE_WIDTH];
            low_hold_valid_reg <= 1'b1;
        end
        else if (rd_low)
        begin
            low_hold_reg <= BYTE_RESET;
            low_hold_valid_reg <= 1'b0;
        end
    end

    // Bus outputs: zero wait states, always OKAY; writes and unmapped
    // addresses are accepted and ignored, reading zero.
    always_ff @(posedge clk)
    begin
        if (sys_rst)
        begin
            hrdata <= 32'h0000_0000;
            hreadyout <= 1'b1;
            hresp <= 1'b0;
        end
        else
        begin
            hreadyout <= 1'b1;
            hresp <= 1'b0;
            if (xfer_valid)
                hrdata <= hrdata_next;
        end
    end

endmodule

// ### tb/err_count_monitor.sv
module err_count_monitor
    import frame_align_err_pkg::*;
(
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic frame_align_err,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    input wire logic hreadyout,
    input wire logic hresp,
    input wire logic [31:0] hrdata
);
    // Idle cycles since the error input was high, so in-flight events land.
    logic [3:0] quiet;
    wire acc = hsel && hready && htrans[1];
    wire rd = acc && !hwrite && hsize == HSIZE_WORD;
    wire hi = rd && haddr == 32'(FRAME_ALIGN_ERR_COUNT_HIGH_ADDR);
    wire lo = rd && haddr == 32'(FRAME_ALIGN_ERR_COUNT_LOW_ADDR);
    always_ff @(posedge clk)
        quiet <= (sys_rst || frame_align_err) ? 4'h0 :
            quiet + 4'(quiet != 4'hf);
    default clocking @(posedge clk); endclocking
    default disable iff (sys_rst);
    sequence s_pair; hi ##2 lo; endsequence
    property p_okay; hreadyout && !hresp; endproperty
    property p_unmapped; acc && !hi && !lo |=> hrdata == 32'h0; endproperty
    property p_upper; hrdata[31:8] == 24'h0; endproperty
    property p_reset; $past(sys_rst) |-> hrdata == 32'h0; endproperty
    property p_stand; !$past(acc) |-> $stable(hrdata); endproperty
    property p_lone; lo ##2 lo ##2 (lo && quiet == 4'hf) |=> hrdata == 32'h0;
    endproperty
    property p_clear; s_pair ##2 (hi && quiet == 4'hf) |=> hrdata == 32'h0;
    endproperty
    a_okay: assert property (p_okay) else $error("bad response");
    a_unmapped: assert property (p_unmapped) else $error("stray data");
    a_upper: assert property (p_upper) else $error("upper bits set");
    a_reset: assert property (p_reset) else $error("reset data");
    a_stand: assert property (p_stand) else $error("data moved");
    a_lone: assert property (p_lone) else $error("low not cleared");
    a_clear: assert property (p_clear) else $error("pair not cleared");
endmodule
bind framing_align_error_counter err_count_monitor u_mon (.*);

// ### tb/tb_framing_align_error_counter.sv
module tb_framing_align_error_counter
    import frame_align_err_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;
    localparam logic [31:0] HI = 32'(FRAME_ALIGN_ERR_COUNT_HIGH_ADDR);
    localparam logic [31:0] LO = 32'(FRAME_ALIGN_ERR_COUNT_LOW_ADDR);
    logic clk = 1'b0, sys_rst = 1'b1, frame_align_err = 1'b0, dph = 1'b0;
    logic hwrite = 1'b0, hreadyout, hresp;
    logic [31:0] haddr = '0, hwdata = '0, hrdata, expq[$];
    logic [1:0] htrans = 2'h0;
    logic [2:0] hsize = 3'h0;
    int fail_count = 0, checks = 0, n, m;
    always #5 clk = ~clk;
    framing_align_error_counter u_dut (.clk(clk), .sys_rst(sys_rst),
        .frame_align_err(frame_align_err), .hsel(1'b1), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
        .hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp),
        .hrdata(hrdata));
    task automatic complete_run();
        $display("checks %0d fail_count %0d", checks, fail_count);
        if (fail_count == 0 && checks > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask
    task automatic check(input logic [31:0] exp, input logic [31:0] got);
        checks++;
        if (got !== exp)
        begin
            fail_count++;
            $display("unexpected at %0t: read %h not %h", $time, got, exp);
        end
    endtask
    // One transfer; the note is queued as the data phase opens.
    task automatic xfer(input logic [31:0] a, input logic [2:0] s,
        input logic w, input logic [7:0] b);
        htrans <= HTRANS_NONSEQ;
        haddr <= a;
        hsize <= s;
        hwrite <= w;
        do @(posedge clk); while (hreadyout !== 1'b1);
        htrans <= 2'h0;
        hwdata <= $urandom;
        expq.push_back({24'h0, b});
        do @(posedge clk); while (hreadyout !== 1'b1);
    endtask
    task automatic rd(input logic [31:0] a, input logic [7:0] b);
        xfer(a, HSIZE_WORD, 1'b0, b);
    endtask
    // Events need a low gap to be seen as separate rising edges.
    task automatic pulse(input int k);
        repeat (k)
        begin
            @(posedge clk) frame_align_err <= 1'b1;
            @(posedge clk) frame_align_err <= 1'b0;
        end
        repeat (16) @(posedge clk);
    endtask
    // The watcher pairs each data phase with the oldest note.
    always @(posedge clk)
    begin
        if (dph)
            check(expq.pop_front(), hrdata);
        dph <= hreadyout && htrans[1] && !sys_rst;
    end
    initial
    begin
        repeat (20000) @(posedge clk);
        fail_count++;
        complete_run();
    end
    initial
    begin
        hwdata <= $urandom(32'ha7c7);
        repeat (6) @(posedge clk);
        sys_rst <= 1'b0;
        rd(HI, 8'h00);
        rd(LO, 8'h00);
        n = 256 + $urandom_range(300);
        pulse(n);
        rd(HI, n[15:8]);
        rd(LO, n[7:0]);
        rd(HI, 8'h00);
        rd(LO, 8'h00);
        pulse(n);
        rd(HI, n[15:8]);
        m = $urandom_range(20, 1);
        pulse(m);
        rd(LO, n[7:0]);
        rd(HI, 8'h00);
        rd(LO, m[7:0]);
        pulse(m);
        xfer(HI, HSIZE_WORD, 1'b1, 8'h00);
        xfer(LO, 3'h0, 1'b0, 8'h00);
        rd(32'h2410, 8'h00);
        rd(LO, m[7:0]);
        rd(LO, 8'h00);
        rd(LO, 8'h00);
        complete_run();
    end
endmodule
